// *** src/cae_pkg.sv ***
// Package with the register map, field layout and encodings of the execution core.
package cae_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned MADDR_W    = 6;
  localparam int unsigned MEM_DEPTH  = 64;
  localparam int unsigned PC_W       = 11;
  localparam int unsigned OP_W       = 4;

  localparam logic [7:0]  REG_INSTR   = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_PC      = 8'h08;
  localparam logic [7:0]  REG_MADDR   = 8'h0C;
  localparam logic [7:0]  REG_MDATA   = 8'h10;
  localparam logic [7:0]  REG_FLAGCLR = 8'h14;

  localparam int unsigned OP_LO      = 0;
  localparam int unsigned OP_HI      = 3;
  localparam int unsigned ADR_LO     = 8;
  localparam int unsigned ADR_HI     = 13;
  localparam int unsigned OPND_LO    = 16;
  localparam int unsigned LIT_HI     = 23;
  localparam int unsigned BR_HI      = 26;

  localparam int unsigned ST_ZF_BIT    = 8;
  localparam int unsigned ST_SLEEP_BIT = 9;
  localparam int unsigned ST_EXPIRE_BIT = 10;
  localparam int unsigned ST_HALT_BIT  = 11;
  localparam int unsigned ST_BUSY_BIT  = 12;

  localparam logic [OP_W-1:0]   OP_DEC_MEM  = 4'h0;
  localparam logic [OP_W-1:0]   OP_DEC_ACC  = 4'h1;
  localparam logic [OP_W-1:0]   OP_INC_MEM  = 4'h2;
  localparam logic [OP_W-1:0]   OP_INC_ACC  = 4'h3;
  localparam logic [OP_W-1:0]   OP_SLEEP    = 4'h4;
  localparam logic [OP_W-1:0]   OP_BRANCH   = 4'h5;
  localparam logic [OP_W-1:0]   OP_LOAD_MEM = 4'h6;
  localparam logic [OP_W-1:0]   OP_LOAD_IMM = 4'h7;
  localparam logic [OP_W-1:0]   OP_STORE    = 4'h8;

  localparam logic [DATA_W-1:0] ACC_RST     = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST      = 11'h000;
  localparam logic [PC_W-1:0]   PC_STEP     = 11'h001;
  localparam logic [DATA_W-1:0] ONE_BYTE    = 8'h01;
  localparam logic [31:0]       ZERO_WORD   = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FILL,
    ST_HALT
  } cae_state_e;

endpackage

// *** src/cae_alu.sv ***
// Increment and decrement unit with zero detection.
`timescale 1ns/10ps
module cae_alu
  import cae_pkg::*;
(
  input  wire logic [DATA_W-1:0] operand,
  input  wire logic              down,
  output logic      [DATA_W-1:0] result,
  output logic                   zero
);

  // The sum is taken at eight bits so that it wraps modulo 256.
  assign result = down ? DATA_W'(operand - ONE_BYTE) : DATA_W'(operand + ONE_BYTE); // [RULE14]
  assign zero   = (result == '0);                                                  // [RULE14]

endmodule

// *** src/cae_core.sv ***
// Instruction execution core for step, move, branch and sleep instructions with an APB slave.
`timescale 1ns/10ps
// Functional notes
// RULE1: subtract_one_in_place writes memory byte minus one back and updates the zero flag.
// RULE2: subtract_one_to_working_register puts memory byte minus one in accumulator, updates zero.
// RULE3: add_one_in_place writes memory byte plus one back and updates the zero flag.
// RULE4: add_one_to_working_register puts memory byte plus one in accumulator, updates zero.
// RULE5: Sleep halts execution and stops the system clock until wake-up.
// RULE6: Memory and register contents are kept unchanged through sleep.
// RULE7: Sleep clears the watchdog counter and its prescaler.
// RULE8: Sleep sets the sleep-entered flag, clears the expiry flag, touches no other flag; a watchdog expiry in the same cycle sets it instead.
// RULE9: unconditional_branch loads the program counter with its address; flags unchanged.
// RULE10: unconditional_branch takes two cycles, the second being a dummy fill cycle.
// RULE11: Copy from memory loads the accumulator from the byte, flags unchanged.
// RULE12: Copy of an immediate loads the literal into the accumulator, flags unchanged.
// RULE13: Copy to memory stores the accumulator into the byte, flags unchanged.
// RULE14: Zero flag set when the wrapped 8-bit step result is zero, else cleared.
module cae_core
  import cae_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              wake,
  input  wire logic              wdt_expire,
  output logic                   sys_clk_en,
  output logic                   wdt_clear
);

  logic [DATA_W-1:0] mem_ff [MEM_DEPTH];
  logic [DATA_W-1:0] acc_ff;
  logic [PC_W-1:0]   pc_ff;
  logic              zf_ff;
  logic              sleep_flag_ff;
  logic              expire_flag_ff;
  logic              wdt_clear_ff;
  logic [MADDR_W-1:0] maddr_ff;
  logic              rvalid_ff;
  logic [31:0]       prdata_ff;
  cae_state_e        state_ff;

  logic [DATA_W-1:0] nxt_acc;
  logic [PC_W-1:0]   nxt_pc;
  logic              nxt_zf;
  cae_state_e        nxt_state;

  // Bus decode.
  wire               xfer       = psel & penable & pready;
  wire               wr_xfer    = xfer & pwrite;
  wire               hit_instr  = (paddr == REG_INSTR);
  wire               hit_status = (paddr == REG_STATUS);
  wire               hit_pc     = (paddr == REG_PC);
  wire               hit_maddr  = (paddr == REG_MADDR);
  wire               hit_mdata  = (paddr == REG_MDATA);
  wire               hit_fclr   = (paddr == REG_FLAGCLR);
  wire               mapped     = hit_instr | hit_status | hit_pc | hit_maddr | hit_mdata
                                  | hit_fclr;
  wire               idle       = (state_ff == ST_IDLE);
  wire               halted     = (state_ff == ST_HALT);
  // An instruction is refused while the core is busy or asleep, a memory write only while asleep.
  wire               instr_bad  = pwrite & hit_instr & ~idle;
  wire               mdata_bad  = pwrite & hit_mdata & halted;
  wire               ro_bad     = pwrite & (hit_status | hit_pc);
  wire               exec_go    = wr_xfer & hit_instr & idle;
  wire               mem_sw_wr  = wr_xfer & hit_mdata & ~halted;

  // Instruction fields.
  wire [OP_W-1:0]    op_w       = pwdata[OP_HI:OP_LO];
  wire [MADDR_W-1:0] ia_w       = pwdata[ADR_HI:ADR_LO];
  wire [DATA_W-1:0]  lit_w      = pwdata[LIT_HI:OPND_LO];
  wire [PC_W-1:0]    br_w       = pwdata[BR_HI:OPND_LO];
  wire [DATA_W-1:0]  mem_rd     = mem_ff[ia_w];
  wire               is_down    = (op_w == OP_DEC_MEM) | (op_w == OP_DEC_ACC);
  wire               is_step    = is_down | (op_w == OP_INC_MEM) | (op_w == OP_INC_ACC);
  wire               to_mem     = (op_w == OP_DEC_MEM) | (op_w == OP_INC_MEM);
  wire               go_step    = exec_go & is_step;
  wire               go_sleep   = exec_go & (op_w == OP_SLEEP);
  wire               go_branch  = exec_go & (op_w == OP_BRANCH);
  wire               go_store   = exec_go & (op_w == OP_STORE);

  wire [DATA_W-1:0]  alu_res;
  wire               alu_zero;

  cae_alu u_alu (
    .operand (mem_rd),
    .down    (is_down),
    .result  (alu_res),
    .zero    (alu_zero)
  );

  wire [31:0] status_w = {19'h0_0000, ~idle & ~halted, halted, expire_flag_ff, sleep_flag_ff,
                          zf_ff, acc_ff};
  wire [31:0] rd_mux   = hit_status ? status_w :
                         hit_pc     ? {21'h00_0000, pc_ff} :
                         hit_maddr  ? {26'h000_0000, maddr_ff} :
                         hit_mdata  ? {24'h00_0000, mem_ff[maddr_ff]} : ZERO_WORD;

  assign pready     = ce & rvalid_ff;
  assign pslverr    = xfer & (~mapped | instr_bad | mdata_bad | ro_bad);
  assign prdata     = prdata_ff;
  assign sys_clk_en = ~halted;                                                      // [RULE5]
  assign wdt_clear  = wdt_clear_ff;

  // Next-state and datapath selection.
  always_comb begin
    nxt_acc   = acc_ff;
    nxt_pc    = pc_ff;
    nxt_zf    = zf_ff;
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (exec_go) begin
          nxt_pc = PC_W'(pc_ff + PC_STEP);
          case (op_w)
            OP_DEC_MEM, OP_INC_MEM: begin
              nxt_zf = alu_zero;                                                    // [RULE1] [RULE3]
            end
            OP_DEC_ACC, OP_INC_ACC: begin
              nxt_acc = alu_res;                                                    // [RULE2] [RULE4]
              nxt_zf  = alu_zero;
            end
            OP_SLEEP: begin
              nxt_state = ST_HALT;                                                  // [RULE5]
            end
            OP_BRANCH: begin
              nxt_pc    = br_w;                                                     // [RULE9]
              nxt_state = ST_FILL;                                                  // [RULE10]
            end
            OP_LOAD_MEM: begin
              nxt_acc = mem_rd;                                                     // [RULE11]
            end
            OP_LOAD_IMM: begin
              nxt_acc = lit_w;                                                      // [RULE12]
            end
            default: begin
              nxt_acc = acc_ff;
            end
          endcase
        end
      end
      ST_FILL: begin
        nxt_state = ST_IDLE;                                                        // [RULE10]
      end
      ST_HALT: begin
        if (wake) begin
          nxt_state = ST_IDLE;                                                      // [RULE5]
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Core state; all registers are held while asleep except by wake.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff   <= ACC_RST;
      pc_ff    <= PC_RST;
      zf_ff    <= 1'b0;
      state_ff <= ST_IDLE;
    end else if (ce) begin
      acc_ff   <= nxt_acc;                                                          // [RULE6]
      pc_ff    <= nxt_pc;
      zf_ff    <= nxt_zf;
      state_ff <= nxt_state;
    end
  end

  // Power-down and expiry flags; a watchdog expiry in the sleep cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_flag_ff  <= 1'b0;
      expire_flag_ff <= 1'b0;
      wdt_clear_ff   <= 1'b0;
    end else if (ce) begin
      wdt_clear_ff <= go_sleep;                                                     // [RULE7]
      if (go_sleep) begin
        sleep_flag_ff <= 1'b1;                                                      // [RULE8]
      end else if (wr_xfer & hit_fclr & pwdata[ST_SLEEP_BIT]) begin
        sleep_flag_ff <= 1'b0;
      end
      if (wdt_expire) begin
        expire_flag_ff <= 1'b1;
      end else if (go_sleep | (wr_xfer & hit_fclr & pwdata[ST_EXPIRE_BIT])) begin
        expire_flag_ff <= 1'b0;                                                     // [RULE8]
      end
    end
  end

  // Data memory: written by step-in-place, store, or software when not asleep.
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (go_step & to_mem) begin
        mem_ff[ia_w] <= alu_res;                                                    // [RULE1] [RULE3]
      end else if (go_store) begin
        mem_ff[ia_w] <= acc_ff;                                                     // [RULE13]
      end else if (mem_sw_wr) begin
        mem_ff[maddr_ff] <= pwdata[DATA_W-1:0];                                     // [RULE6]
      end
    end
  end

  // Bus side registers; read data is captured before the access completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maddr_ff  <= '0;
      rvalid_ff <= 1'b0;
      prdata_ff <= ZERO_WORD;
    end else if (ce) begin
      rvalid_ff <= psel & ~xfer;
      if (psel & ~rvalid_ff) begin
        prdata_ff <= rd_mux;
      end
      if (wr_xfer & hit_maddr) begin
        maddr_ff <= pwdata[MADDR_W-1:0];
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_branch_start;
    ce && go_branch;
  endsequence

  sequence s_fill_cycle;
    ce && state_ff == ST_FILL;
  endsequence

  property p_dec_mem;
    ce && exec_go && op_w == OP_DEC_MEM |=>
      mem_ff[$past(ia_w)] == $past(mem_rd) - 8'h01 && zf_ff == (mem_ff[$past(ia_w)] == 8'h00);
  endproperty
  a_dec_mem: assert property (p_dec_mem) else $error("in-place decrement wrong"); // [RULE1]

  property p_dec_acc;
    ce && exec_go && op_w == OP_DEC_ACC |=>
      acc_ff == $past(mem_rd) - 8'h01 && mem_ff[$past(ia_w)] == $past(mem_rd);
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("decrement to accumulator wrong"); // [RULE2]

  property p_inc_mem;
    ce && exec_go && op_w == OP_INC_MEM |=> mem_ff[$past(ia_w)] == $past(mem_rd) + 8'h01;
  endproperty
  a_inc_mem: assert property (p_inc_mem) else $error("in-place increment wrong"); // [RULE3]

  property p_inc_acc;
    ce && exec_go && op_w == OP_INC_ACC |=>
      acc_ff == $past(mem_rd) + 8'h01 && mem_ff[$past(ia_w)] == $past(mem_rd);
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("increment to accumulator wrong"); // [RULE4]

  property p_halt_hold;
    ce && halted && !wake |=> halted && !sys_clk_en && $stable(pc_ff);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("core left sleep without wake"); // [RULE5]

  property p_halt_keep;
    halted |=> $stable(acc_ff) && $stable(zf_ff)
      && mem_ff[$past(maddr_ff)] == $past(mem_ff[maddr_ff]);
  endproperty
  a_halt_keep: assert property (p_halt_keep) else $error("state changed during sleep"); // [RULE6]

  property p_wdt_clear;
    ce && go_sleep |=> wdt_clear ##1 (!wdt_clear || !$past(ce));
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear pulse missing"); // [RULE7]

  property p_sleep_flags;
    ce && go_sleep && !wdt_expire |=> sleep_flag_ff && !expire_flag_ff && $stable(zf_ff);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong"); // [RULE8]

  property p_branch_pc;
    s_branch_start |=> pc_ff == $past(br_w) && $stable(zf_ff) && $stable(acc_ff);
  endproperty
  a_branch_pc: assert property (p_branch_pc) else $error("branch target not loaded"); // [RULE9]

  property p_branch_two;
    s_branch_start ##1 s_fill_cycle |=> idle && $stable(pc_ff);
  endproperty
  a_branch_two: assert property (p_branch_two) else $error("branch not two cycles"); // [RULE10]

  property p_load_mem;
    ce && exec_go && op_w == OP_LOAD_MEM |=> acc_ff == $past(mem_rd) && $stable(zf_ff);
  endproperty
  a_load_mem: assert property (p_load_mem) else $error("copy from memory wrong"); // [RULE11]

  property p_load_imm;
    ce && exec_go && op_w == OP_LOAD_IMM |=> acc_ff == $past(lit_w) && $stable(zf_ff);
  endproperty
  a_load_imm: assert property (p_load_imm) else $error("immediate copy wrong"); // [RULE12]

  property p_store;
    ce && go_store |=> mem_ff[$past(ia_w)] == $past(acc_ff) && $stable(zf_ff);
  endproperty
  a_store: assert property (p_store) else $error("copy to memory wrong"); // [RULE13]

  property p_zero_flag;
    ce && go_step |=> zf_ff == ($past(alu_res) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // [RULE14]

  property p_slp_instr;
    halted && psel && penable && pready && pwrite && hit_instr |-> pslverr;
  endproperty
  a_slp_instr: assert property (p_slp_instr) else $error("sleep took instruction"); // [RULE5]

  property p_wake_exit;
    ce && halted && wake |=> idle && sys_clk_en;
  endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("no wake from sleep"); // [RULE5]

  property p_slp_mem;
    halted && psel && penable && pready && pwrite && hit_mdata |-> pslverr;
  endproperty
  a_slp_mem: assert property (p_slp_mem) else $error("memory written in sleep"); // [RULE6]

  property p_wdt_quiet;
    ce && !go_sleep |=> !wdt_clear;
  endproperty
  a_wdt_quiet: assert property (p_wdt_quiet) else $error("stray watchdog clear"); // [RULE7]

  property p_sleep_set;
    ce && go_sleep |=> sleep_flag_ff && $stable(acc_ff);
  endproperty
  a_sleep_set: assert property (p_sleep_set) else $error("sleep flag not set"); // [RULE8]

  property p_branch_fill;
    s_branch_start |=> state_ff == ST_FILL && status_w[ST_BUSY_BIT];
  endproperty
  a_branch_fill: assert property (p_branch_fill) else $error("no fill after branch"); // [RULE10]

  property p_load_keep;
    ce && exec_go && op_w == OP_LOAD_MEM |=> mem_ff[$past(ia_w)] == $past(mem_rd);
  endproperty
  a_load_keep: assert property (p_load_keep) else $error("copy changed memory"); // [RULE11]

endmodule

// *** testbench/cae_wdog_model.sv ***
// Behavioural watchdog counter and wake source facing the core's power-down outputs.
`timescale 1ns/10ps
module cae_wdog_model #(
  parameter int WAKE_DLY = 6
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sys_clk_en,
  input  wire logic       wdt_clear,
  input  wire logic       wake_arm,
  output logic      [7:0] wdt_cnt,
  output logic            wake
);
  logic [7:0] cnt_ff;
  logic [7:0] dly_ff;
  // The counter only advances while the system clock runs, so a cleared count stays visible.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 8'h00;
      dly_ff <= 8'h00;
    end else begin
      cnt_ff <= wdt_clear ? 8'h00 : (sys_clk_en ? cnt_ff + 8'h01 : cnt_ff);
      dly_ff <= (wake_arm && !sys_clk_en) ? dly_ff + 8'h01 : 8'h00;
    end
  end
  assign wdt_cnt = cnt_ff;
  assign wake    = wake_arm && !sys_clk_en && (dly_ff >= 8'(WAKE_DLY));
endmodule

// *** testbench/tb.sv ***
// Self-checking testbench for the instruction execution core.
`timescale 1ns/10ps
module tb
  import cae_pkg::*;
;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        wake, wdt_expire, sys_clk_en, wdt_clear, wake_arm;
  logic [7:0]  wdt_cnt, acc_m;
  logic        zf_m, sf_m, xf_m;
  logic [10:0] pc_m;
  int          error_cnt, compares, clr_seen;

  cae_core cae_core_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake(wake), .wdt_expire(wdt_expire), .sys_clk_en(sys_clk_en),
    .wdt_clear(wdt_clear));
  cae_wdog_model cae_wdog_model_i (.pclk(pclk), .presetn(presetn), .sys_clk_en(sys_clk_en),
    .wdt_clear(wdt_clear), .wake_arm(wake_arm), .wdt_cnt(wdt_cnt), .wake(wake));

  always #5 pclk = ~pclk;
  always @(negedge pclk) if (wdt_clear === 1'h1) clr_seen++;

  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] st_exp(input logic asl);
    logic [31:0] w;
    w = ZERO_WORD;
    w[7:0] = acc_m;
    w[ST_ZF_BIT] = zf_m;
    w[ST_SLEEP_BIT] = sf_m;
    w[ST_EXPIRE_BIT] = xf_m;
    w[ST_HALT_BIT] = asl;
    return w;
  endfunction

  // Answer taken at the rising edge that sees pready; hold keeps the bus for a back-to-back setup.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic eerr, input logic hold, output logic [31:0] rd);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    if (pready !== 1'h1) begin
      error_cnt++;
      wrap_up();
    end
    rd = prdata;
    chk({31'h0, pslverr}, {31'h0, eerr});
    if (!hold) begin
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic eerr);
    logic [31:0] r;
    apb(1'h1, a, d, eerr, 1'h0, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'h0, a, ZERO_WORD, 1'h0, 1'h0, r);
    chk(r, exp);
  endtask

  task automatic exec(input logic [3:0] op, input logic [5:0] a, input logic [10:0] opnd);
    logic [31:0] w;
    w = ZERO_WORD;
    w[OP_HI:OP_LO] = op;
    w[ADR_HI:ADR_LO] = a;
    w[BR_HI:OPND_LO] = opnd;
    wr(REG_INSTR, w, 1'h0);
    pc_m = (op == OP_BRANCH) ? opnd : pc_m + 11'h001;
  endtask

  task automatic mem_wr(input logic [5:0] a, input logic [7:0] v);
    wr(REG_MADDR, {26'h0, a}, 1'h0);
    wr(REG_MDATA, {24'h0, v}, 1'h0);
  endtask

  task automatic mem_chk(input logic [5:0] a, input logic [7:0] v);
    wr(REG_MADDR, {26'h0, a}, 1'h0);
    rd_chk(REG_MDATA, {24'h0, v});
  endtask

  task automatic t_step(input logic [3:0] op, input logic [5:0] a, input logic [7:0] v);
    logic [7:0] r;
    mem_wr(a, v);
    r = (op == OP_DEC_MEM || op == OP_DEC_ACC) ? v - 8'h01 : v + 8'h01;
    exec(op, a, 11'h000);
    zf_m = (r == 8'h00);
    if (op == OP_DEC_ACC || op == OP_INC_ACC)
      acc_m = r;
    else
      v = r;
    rd_chk(REG_STATUS, st_exp(1'h0));
    mem_chk(a, v);
  endtask

  task automatic t_move();
    mem_wr(6'h07, 8'h3C);
    exec(OP_LOAD_MEM, 6'h07, 11'h000);
    acc_m = 8'h3C;
    rd_chk(REG_STATUS, st_exp(1'h0));
    exec(OP_LOAD_IMM, 6'h00, 11'h0A5);
    acc_m = 8'hA5;
    rd_chk(REG_STATUS, st_exp(1'h0));
    exec(OP_STORE, 6'h3F, 11'h000);
    mem_chk(6'h3F, 8'hA5);
    rd_chk(REG_STATUS, st_exp(1'h0));
  endtask

  task automatic t_branch();
    logic [31:0] w;
    logic [31:0] r;
    w = ZERO_WORD;
    w[OP_HI:OP_LO] = OP_BRANCH;
    w[BR_HI:OPND_LO] = 11'h5A3;
    apb(1'h1, REG_INSTR, w, 1'h0, 1'h1, r);
    pc_m = 11'h5A3;
    // The back-to-back read is captured in the fill cycle, so the busy bit must show.
    apb(1'h0, REG_STATUS, ZERO_WORD, 1'h0, 1'h0, r);
    chk(r, st_exp(1'h0) | (32'h0000_0001 << ST_BUSY_BIT));
    rd_chk(REG_PC, {21'h0, pc_m});
    rd_chk(REG_STATUS, st_exp(1'h0));
    exec(4'hF, 6'h00, 11'h000);
    rd_chk(REG_PC, {21'h0, pc_m});
  endtask

  task automatic t_sleep();
    int n;
    wdt_expire <= 1'h1;
    @(posedge pclk);
    wdt_expire <= 1'h0;
    @(posedge pclk);
    xf_m = 1'h1;
    rd_chk(REG_STATUS, st_exp(1'h0));
    clr_seen = 0;
    exec(OP_SLEEP, 6'h00, 11'h000);
    sf_m = 1'h1;
    xf_m = 1'h0;
    @(posedge pclk);
    chk({31'h0, sys_clk_en}, 32'h0000_0000);
    chk({24'h0, wdt_cnt}, 32'h0000_0000);
    chk(clr_seen, 32'h0000_0001);
    rd_chk(REG_STATUS, st_exp(1'h1));
    wr(REG_INSTR, {28'h0, OP_INC_ACC}, 1'h1);
    wr(REG_MDATA, 32'h0000_00EE, 1'h1);
    rd_chk(REG_PC, {21'h0, pc_m});
    wake_arm <= 1'h1;
    n = 0;
    while (sys_clk_en !== 1'h1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (sys_clk_en !== 1'h1) begin
      error_cnt++;
      wrap_up();
    end
    wake_arm <= 1'h0;
    chk({31'h0, sys_clk_en}, 32'h0000_0001);
    rd_chk(REG_STATUS, st_exp(1'h0));
    mem_chk(6'h3F, 8'hA5);
  endtask

  task automatic t_misc();
    logic [31:0] r;
    wr(REG_FLAGCLR, 32'h0000_0600, 1'h0);
    sf_m = 1'h0;
    rd_chk(REG_STATUS, st_exp(1'h0));
    rd_chk(REG_FLAGCLR, ZERO_WORD);
    apb(1'h0, 8'h18, ZERO_WORD, 1'h1, 1'h0, r);
    wr(REG_STATUS, 32'hFFFF_FFFF, 1'h1);
    wr(REG_PC, 32'h0000_0123, 1'h1);
    rd_chk(REG_STATUS, st_exp(1'h0));
    ce <= 1'h0;
    fork
      rd_chk(REG_PC, {21'h0, pc_m});
      begin
        repeat (4) @(posedge pclk);
        ce <= 1'h1;
      end
    join
  endtask

  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    ce = 1'h1;
    {psel, penable, pwrite, wdt_expire, wake_arm} = 5'h00;
    paddr = 8'h00;
    pwdata = ZERO_WORD;
    {acc_m, zf_m, sf_m, xf_m, pc_m} = 22'h0;
    error_cnt = 0;
    compares = 0;
    clr_seen = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd_chk(REG_STATUS, st_exp(1'h0));
    t_step(OP_DEC_MEM, 6'h01, 8'h01);
    t_step(OP_DEC_MEM, 6'h02, 8'h00);
    t_step(OP_DEC_ACC, 6'h03, 8'h05);
    t_step(OP_INC_MEM, 6'h04, 8'hFF);
    t_step(OP_INC_ACC, 6'h05, 8'h7F);
    t_step(OP_INC_ACC, 6'h06, 8'hFF);
    t_move();
    t_branch();
    t_sleep();
    t_misc();
    wrap_up();
  end
endmodule
